// [verilog/vpw_pkg.sv]
//
// Contract
// - Passive bus of nominally 280 us after data ends the frame as end-of-frame.
// - End-of-frame flag is raised once a full end-of-frame passive period is received.
// - Interframe separation adds 20 us, giving 300 us passive since the last edge.
// - After end-of-frame, wait out interframe separation before driving start-of-frame.
// - A rising edge during that wait resynchronises timing and counts as start-of-frame.
// - The block never drives a break symbol onto the bus.
// - A break seen while transmitting is a transmit error and releases the bus at once.
// - A break seen while receiving sets the invalid-symbol flag and drops the frame; bytes of it already completed stay in the receive FIFO.
// - A break while receiving also clears the fast receive mode enable.
// - Passive bus beyond 300 us is idle; transmission may start at once.
// - A bit is the bus level plus the time between transitions; levels alternate.
// - Every data byte, check byte included, starts with a passive bit.
// - Logic zero is 64 us passive or 128 us active.
// - Logic one is 128 us passive or 64 us active.
// - Break is an active period of at least 240 us.
// - Start-of-frame is an active period of nominally 200 us.
// - End-of-data is a passive period of nominally 200 us.
// - Without a response byte, 80 us more passive turns end-of-data into end-of-frame.
// - The normalisation bit is timed like a data bit and only precedes response bytes.
// - End-of-data, end-of-frame, separation and idle are measured, never driven.
// - Receive classification resolves to one tick; adjacent windows differ by one tick.
// - Receive windows leave no gaps between neighbouring symbols.
// - A waiting node seeing a rising edge after valid end-of-frame starts sending at once.
package vpw_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MUX_TICK_NS = 1000;
  localparam int TICK_CYC = (MUX_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_DIV = 4;
  localparam int DIV_W = 8;
  localparam int DUR_W = 9;
  localparam logic [DUR_W-1:0] DUR_MAX = 9'h1FF;
  localparam logic [DUR_W-1:0] BIT_SHORT_US = 9'h040;
  localparam logic [DUR_W-1:0] BIT_LONG_US = 9'h080;
  localparam logic [DUR_W-1:0] SOF_US = 9'h0C8;
  localparam logic [DUR_W-1:0] EOD_US = 9'h0C8;
  localparam logic [DUR_W-1:0] EOD_EXT_US = 9'h050;
  localparam logic [DUR_W-1:0] EOF_US = EOD_US + EOD_EXT_US;
  localparam logic [DUR_W-1:0] IFS_US = 9'h014;
  localparam logic [DUR_W-1:0] IFS_END_US = EOF_US + IFS_US;
  localparam logic [DUR_W-1:0] BREAK_US = 9'h0F0;
  localparam logic [DUR_W-1:0] WIN_MIN_US = 9'h022;
  localparam logic [DUR_W-1:0] WIN_SHORT_MAX = 9'h060;
  localparam logic [DUR_W-1:0] EOD_MIN_US = 9'h0A4;
  localparam logic [DUR_W-1:0] WIN_LONG_MAX = EOD_MIN_US - 9'h001;
  localparam logic [DUR_W-1:0] WIN_SYM_MAX = BREAK_US - 9'h001;

  typedef enum logic [1:0] {SEG_BAD, SEG_SHORT, SEG_LONG, SEG_SYM} vpw_seg_e;
  typedef enum logic [1:0] {RX_WAIT, RX_SOF, RX_FRAME, RX_EOD} vpw_rx_e;
  typedef enum logic [1:0] {TX_OFF, TX_SOF, TX_BITS} vpw_tx_e;

  // Segment length class; each upper bound is one tick below the next lower bound
  function automatic vpw_seg_e vpw_classify(input logic [DUR_W-1:0] d);
    if (d < WIN_MIN_US) return SEG_BAD;
    else if (d <= WIN_SHORT_MAX) return SEG_SHORT;
    else if (d <= WIN_LONG_MAX) return SEG_LONG;
    else if (d <= WIN_SYM_MAX) return SEG_SYM;
    else return SEG_BAD;
  endfunction

  // Bit length from level and value: passive zero and active one are short
  function automatic logic [DUR_W-1:0] vpw_bit_us(input logic active, input logic bit_val);
    return (active ^ bit_val) ? BIT_LONG_US : BIT_SHORT_US;
  endfunction
endpackage

// [verilog/vpw_symbol_timing_link.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Receive byte buffer
// ----------------------------------------
module vpw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("vpw_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
    end else if (in_valid && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q <= '0;
    end else if (out_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ----------------------------------------
// Symbol timing link
// ----------------------------------------
module vpw_symbol_timing_link
  import vpw_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic line_receive_input,
  output logic line_transmit_output,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic fast_mode_set,
  input wire logic fast_mode_clear,
  output logic fast_receive_mode_enable,
  input wire logic invalid_clear,
  output logic invalid_symbol_flag,
  output logic eof_flag,
  output logic tx_error,
  output logic frame_abort,
  output logic rx_overrun,
  output logic bus_idle
);
  if (TICK_CYC < FAST_DIV || TICK_CYC % FAST_DIV != 0 || TICK_CYC > 255) begin : g_chk
    $error("tick divider does not fit the clock rate");
  end

  // ----------------------------------------
  // Line input synchroniser
  // ----------------------------------------
  logic [2:0] sync_q;
  logic lvl_q;
  logic lvl_chg;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_q <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], line_receive_input};
      if (sync_q[2] == sync_q[1]) begin
        lvl_q <= sync_q[2];
      end
    end
  end

  assign lvl_chg = (sync_q[2] == sync_q[1]) && (sync_q[2] != lvl_q);
  assign rise = lvl_chg && sync_q[2];
  assign fall = lvl_chg && !sync_q[2];

  // ----------------------------------------
  // Multiplex tick divider
  // ----------------------------------------
  vpw_tx_e tx_st_q;
  logic tx_start;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_max;
  logic tick;

  assign div_max = fast_receive_mode_enable ? DIV_W'(TICK_CYC / FAST_DIV - 1) : DIV_W'(TICK_CYC - 1);
  assign tick = (div_q >= div_max);

  // Realigned to each bus edge while not sending, and at a start so the first symbol is whole
  always_ff @(posedge clk) begin
    if (reset || tx_start || (lvl_chg && tx_st_q == TX_OFF)) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Segment duration measurement
  // ----------------------------------------
  logic [DUR_W-1:0] dur_q;
  logic [DUR_W-1:0] dur_nx;
  logic step;
  logic eod_hit;
  logic eof_hit;
  logic brk_hit;
  logic eof_seen;
  vpw_seg_e seg;
  logic bit_now;

  assign dur_nx = dur_q + 9'h001;
  assign step = tick && (dur_q != DUR_MAX);

  always_ff @(posedge clk) begin
    if (reset || lvl_chg) begin
      dur_q <= '0;
    end else if (step) begin
      dur_q <= dur_nx;
    end
  end

  assign eod_hit = step && !lvl_q && (dur_nx == EOD_MIN_US);
  assign eof_hit = step && !lvl_q && (dur_nx == EOF_US);
  assign brk_hit = step && lvl_q && (dur_nx == BREAK_US);
  assign eof_seen = !lvl_q && (dur_q >= EOF_US);
  assign bus_idle = !lvl_q && (dur_q > IFS_END_US);
  assign seg = vpw_classify(dur_q);
  assign bit_now = lvl_q ^ (seg == SEG_LONG);

  // ----------------------------------------
  // Receive framing
  // ----------------------------------------
  vpw_rx_e rx_st_q;
  logic nb_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_sh_q;
  logic push_q;
  logic [7:0] push_data_q;
  logic bad_q;
  logic brk_rx;
  logic fifo_ready;

  assign brk_rx = brk_hit && (rx_st_q == RX_FRAME || rx_st_q == RX_EOD);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_st_q <= RX_WAIT;
      nb_q <= 1'b0;
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      push_q <= 1'b0;
      push_data_q <= 8'h00;
      bad_q <= 1'b0;
      eof_flag <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      push_q <= 1'b0;
      bad_q <= 1'b0;
      eof_flag <= 1'b0;
      frame_abort <= 1'b0;
      if (brk_hit) begin
        if (brk_rx) begin
          bad_q <= 1'b1;
          frame_abort <= 1'b1;
        end
        rx_st_q <= RX_WAIT;
      end else begin
        unique case (rx_st_q)
          RX_WAIT: begin
            if (rise) begin
              rx_st_q <= RX_SOF;
            end
          end
          RX_SOF: begin
            if (fall) begin
              if (seg == SEG_SYM) begin
                rx_st_q <= RX_FRAME;
                rx_cnt_q <= 3'h0;
                nb_q <= 1'b0;
              end else begin
                rx_st_q <= RX_WAIT;
              end
            end
          end
          RX_FRAME: begin
            if (lvl_chg) begin
              if (seg == SEG_SHORT || seg == SEG_LONG) begin
                if (nb_q) begin
                  nb_q <= 1'b0;
                end else begin
                  rx_sh_q <= {rx_sh_q[6:0], bit_now};
                  rx_cnt_q <= rx_cnt_q + 3'h1;
                  if (rx_cnt_q == 3'h7) begin
                    push_q <= 1'b1;
                    push_data_q <= {rx_sh_q[6:0], bit_now};
                  end
                end
              end else begin
                bad_q <= 1'b1;
                frame_abort <= 1'b1;
                rx_st_q <= RX_WAIT;
              end
            end else if (eod_hit) begin
              if (rx_cnt_q != 3'h0 || nb_q) begin
                bad_q <= 1'b1;
                frame_abort <= 1'b1;
                rx_st_q <= RX_WAIT;
              end else begin
                rx_st_q <= RX_EOD;
              end
            end
          end
          RX_EOD: begin
            if (rise) begin
              rx_st_q <= RX_FRAME;
              rx_cnt_q <= 3'h0;
              nb_q <= 1'b1;
            end else if (eof_hit) begin
              eof_flag <= 1'b1;
              rx_st_q <= RX_WAIT;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      invalid_symbol_flag <= 1'b0;
    end else if (bad_q) begin
      invalid_symbol_flag <= 1'b1;
    end else if (invalid_clear) begin
      invalid_symbol_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fast_receive_mode_enable <= 1'b0;
    end else if (brk_rx) begin
      fast_receive_mode_enable <= 1'b0;
    end else if (fast_mode_set) begin
      fast_receive_mode_enable <= 1'b1;
    end else if (fast_mode_clear) begin
      fast_receive_mode_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= push_q && !fifo_ready;
    end
  end

  vpw_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_q),
    .in_data(push_data_q),
    .in_ready(fifo_ready),
    .out_valid(rx_valid),
    .out_data(rx_byte),
    .out_ready(rx_ready)
  );

  // ----------------------------------------
  // Transmit symbol generator
  // ----------------------------------------
  logic [7:0] hold_q;
  logic hold_vld_q;
  logic [DUR_W-1:0] tx_cnt_q;
  logic [DUR_W-1:0] tx_len_q;
  logic [7:0] tx_sh_q;
  logic [2:0] bits_left_q;
  logic tx_abort;
  logic sym_end;
  logic hold_take;

  assign tx_ready = !hold_vld_q;
  assign tx_abort = (tx_st_q != TX_OFF) && brk_hit;
  assign tx_start = (tx_st_q == TX_OFF) && hold_vld_q && (bus_idle || (rise && eof_seen));
  assign sym_end = (tx_st_q != TX_OFF) && tick && ((tx_cnt_q + 9'h001) == tx_len_q);
  assign hold_take = sym_end && !tx_abort && (bits_left_q == 3'h0) && hold_vld_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= 8'h00;
      hold_vld_q <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      hold_q <= tx_byte;
      hold_vld_q <= 1'b1;
    end else if (hold_take || tx_abort) begin
      hold_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_st_q <= TX_OFF;
      line_transmit_output <= 1'b0;
      tx_cnt_q <= '0;
      tx_len_q <= '0;
      tx_sh_q <= 8'h00;
      bits_left_q <= 3'h0;
      tx_error <= 1'b0;
    end else begin
      tx_error <= 1'b0;
      if (tx_abort) begin
        tx_st_q <= TX_OFF;
        line_transmit_output <= 1'b0;
        tx_error <= 1'b1;
      end else if (tx_start) begin
        tx_st_q <= TX_SOF;
        line_transmit_output <= 1'b1;
        tx_cnt_q <= '0;
        tx_len_q <= SOF_US;
        bits_left_q <= 3'h0;
      end else if (sym_end) begin
        tx_cnt_q <= '0;
        if (bits_left_q != 3'h0) begin
          line_transmit_output <= !line_transmit_output;
          tx_len_q <= vpw_bit_us(!line_transmit_output, tx_sh_q[7]);
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          bits_left_q <= bits_left_q - 3'h1;
          tx_st_q <= TX_BITS;
        end else if (hold_vld_q) begin
          line_transmit_output <= !line_transmit_output;
          tx_len_q <= vpw_bit_us(!line_transmit_output, hold_q[7]);
          tx_sh_q <= {hold_q[6:0], 1'b0};
          bits_left_q <= 3'h7;
          tx_st_q <= TX_BITS;
        end else begin
          line_transmit_output <= 1'b0;
          tx_st_q <= TX_OFF;
        end
      end else if (tick && tx_st_q != TX_OFF) begin
        tx_cnt_q <= tx_cnt_q + 9'h001;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [DUR_W-1:0] tx_run_q;

  always_ff @(posedge clk) begin
    if (reset || !line_transmit_output) begin
      tx_run_q <= '0;
    end else if (tick && tx_run_q != DUR_MAX) begin
      tx_run_q <= tx_run_q + 9'h001;
    end
  end

  eof_timing_a: assert property (@(posedge clk) disable iff (reset) eof_flag |-> (!lvl_q && dur_q == EOF_US))
    else $error("end-of-frame flag without full passive period");
  no_break_drive_a: assert property (@(posedge clk) disable iff (reset) tx_run_q < BREAK_US)
    else $error("transmitter drove an active period of break length");
  break_tx_stop_a: assert property (@(posedge clk) disable iff (reset)
    (brk_hit && tx_st_q != TX_OFF) |=> (!line_transmit_output && tx_error && tx_st_q == TX_OFF))
    else $error("transmitter kept driving after a break");
  break_rx_flag_a: assert property (@(posedge clk) disable iff (reset)
    brk_rx |=> frame_abort ##1 invalid_symbol_flag)
    else $error("break during reception not flagged");
  break_fast_a: assert property (@(posedge clk) disable iff (reset) brk_rx |=> !fast_receive_mode_enable)
    else $error("fast receive mode survived a break");
  idle_start_a: assert property (@(posedge clk) disable iff (reset)
    (tx_st_q == TX_OFF && hold_vld_q && bus_idle) |=> (tx_st_q == TX_SOF && line_transmit_output))
    else $error("no start on idle bus");
  edge_start_a: assert property (@(posedge clk) disable iff (reset)
    (tx_st_q == TX_OFF && hold_vld_q && rise && eof_seen) |=> tx_st_q == TX_SOF)
    else $error("no start on rising edge after end-of-frame");
  first_passive_a: assert property (@(posedge clk) disable iff (reset)
    ($past(tx_st_q) == TX_SOF && tx_st_q == TX_BITS) |-> !line_transmit_output)
    else $error("first data bit not passive");
  passive_only_a: assert property (@(posedge clk) disable iff (reset) (tx_st_q == TX_OFF) |-> !line_transmit_output)
    else $error("line driven while no frame is sent");
  window_edge_a: assert property (@(posedge clk) disable iff (reset)
    (lvl_chg && dur_q == WIN_SHORT_MAX) |-> (seg == SEG_SHORT && vpw_classify(dur_nx) == SEG_LONG))
    else $error("adjacent windows not one tick apart");
endmodule

// [verilog/placeholder_unused.sv]
`timescale 1ns/1ps

// [testbench/vpw_partner.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Far-side node on the single-wire bus
// ----------------------------------------
module vpw_partner (
  input wire logic clk,
  input wire logic fast,
  input wire logic dev_drive,
  output logic drive
);
  int dur[9];

  initial begin
    drive = 1'b0;
  end

  // Holds one bus level for a whole number of ticks
  task automatic send_seg(input logic level, input int ticks);
    int cyc;
    cyc = ticks * (fast ? 25 : 100);
    drive <= level;
    repeat (cyc) @(posedge clk);
  endtask

  // Start-of-frame, then one byte most significant bit first; leaves the last bit active
  task automatic send_byte_frame(input logic [7:0] b);
    send_seg(1'b1, 200);
    for (int k = 7; k >= 0; k--) begin
      logic act;
      act = ((7 - k) % 2) == 1;
      send_seg(act, (act ^ b[k]) ? 128 : 64);
    end
  endtask

  // One passive bit, then an active period long enough to be a break
  task automatic send_break();
    send_seg(1'b0, 64);
    send_seg(1'b1, 260);
    send_seg(1'b0, 10);
  endtask

  // Measures start-of-frame and eight bit periods sent by the device, in clock cycles
  task automatic catch_frame();
    int n;
    logic lvl;
    n = 0;
    while (dev_drive !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    for (int k = 0; k < 9; k++) begin
      lvl = dev_drive;
      n = 0;
      while (dev_drive === lvl && n < 20000) begin
        @(negedge clk);
        n++;
      end
      dur[k] = n;
    end
  endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
  import vpw_pkg::*;
  logic clk;
  logic reset;
  logic line_receive_input;
  logic line_transmit_output;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_ready;
  logic fast_mode_set;
  logic invalid_clear;
  logic fast_receive_mode_enable;
  logic invalid_symbol_flag;
  logic eof_flag;
  logic tx_error;
  logic frame_abort;
  logic rx_overrun;
  logic bus_idle;
  logic partner_drive;
  logic abort_seen;
  logic txerr_seen;
  logic [31:0] seed_q;
  logic [7:0] model_q[$];
  int bad_count;
  int compares;

  // Wired bus: active when either node drives
  assign line_receive_input = line_transmit_output | partner_drive;

  vpw_symbol_timing_link #(.FIFO_DEPTH(8)) i_dut (
    .clk(clk), .reset(reset), .line_receive_input(line_receive_input),
    .line_transmit_output(line_transmit_output), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .fast_mode_set(fast_mode_set), .fast_mode_clear(1'b0),
    .fast_receive_mode_enable(fast_receive_mode_enable), .invalid_clear(invalid_clear),
    .invalid_symbol_flag(invalid_symbol_flag), .eof_flag(eof_flag), .tx_error(tx_error),
    .frame_abort(frame_abort), .rx_overrun(rx_overrun), .bus_idle(bus_idle)
  );

  vpw_partner i_partner (
    .clk(clk), .fast(fast_receive_mode_enable), .dev_drive(line_transmit_output), .drive(partner_drive)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [31:0] to_ticks(input int cyc);
    return 32'((cyc + 12) / 25);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Pops the FIFO head and compares it with the model queue
  task automatic pop_check();
    logic [7:0] e;
    e = (model_q.size() > 0) ? model_q.pop_front() : 8'h00;
    check(32'(rx_valid), 32'h1);
    check(32'(rx_byte), 32'(e));
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (frame_abort === 1'b1) abort_seen <= 1'b1;
    if (tx_error === 1'b1) txerr_seen <= 1'b1;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [7:0] b;
    reset = 1'b1;
    tx_byte = 8'h00;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    fast_mode_set = 1'b0;
    invalid_clear = 1'b0;
    abort_seen = 1'b0;
    txerr_seen = 1'b0;
    seed_q = 32'hE36F894E;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    fast_mode_set <= 1'b1;
    @(posedge clk);
    fast_mode_set <= 1'b0;
    @(negedge clk);
    check(32'(line_transmit_output), 32'h0);
    check(32'(tx_ready), 32'h1);
    check(32'(rx_valid), 32'h0);
    check(32'(bus_idle), 32'h0);
    check(32'(fast_receive_mode_enable), 32'h1);
    n = 0;
    while (bus_idle !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    check(32'(bus_idle), 32'h1);
    $display("test reset and idle done");

    // Transmit one byte onto an idle bus; own echo lands in the FIFO
    seed_q = xs(seed_q);
    b = seed_q[7:0];
    model_q.push_back(b);
    @(posedge clk);
    tx_byte <= b;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    i_partner.catch_frame();
    check(to_ticks(i_partner.dur[0]), 32'(SOF_US));
    for (int k = 1; k < 9; k++) begin
      logic act;
      act = (k % 2) == 0;
      check(to_ticks(i_partner.dur[k]), (act ^ b[8 - k]) ? 32'd128 : 32'd64);
    end
    n = 0;
    while (eof_flag !== 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    check(to_ticks(n), 32'd280);
    check(32'(line_transmit_output), 32'h0);
    n = 0;
    while (bus_idle !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(to_ticks(n), 32'd21);
    pop_check();
    $display("test transmit frame done");

    // Partner frame: one whole byte, then a break in mid-byte
    seed_q = xs(seed_q);
    b = seed_q[7:0];
    model_q.push_back(b);
    i_partner.send_byte_frame(b);
    i_partner.send_break();
    @(negedge clk);
    check(32'(abort_seen), 32'h1);
    check(32'(invalid_symbol_flag), 32'h1);
    check(32'(fast_receive_mode_enable), 32'h0);
    check(32'(txerr_seen), 32'h0);
    check(32'(eof_flag), 32'h0);
    check(32'(line_transmit_output), 32'h0);
    pop_check();
    check(32'(rx_valid), 32'h0);
    @(posedge clk);
    invalid_clear <= 1'b1;
    @(posedge clk);
    invalid_clear <= 1'b0;
    @(negedge clk);
    check(32'(invalid_symbol_flag), 32'h0);
    $display("test receive and break done");

    // Resend after the break; the block must hold off until the bus is idle
    seed_q = xs(seed_q);
    @(posedge clk);
    fast_mode_set <= 1'b1;
    tx_byte <= seed_q[7:0];
    tx_valid <= 1'b1;
    @(posedge clk);
    fast_mode_set <= 1'b0;
    tx_valid <= 1'b0;
    @(negedge clk);
    check(32'(tx_ready), 32'h0);
    check(32'(line_transmit_output), 32'h0);
    n = 0;
    while (line_transmit_output !== 1'b1 && n < 10000) begin
      @(negedge clk);
      n++;
    end
    check(32'(line_transmit_output), 32'h1);
    check(32'(bus_idle), 32'h1);
    check(32'(txerr_seen), 32'h0);
    $display("test resend after break done");
    results();
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (99000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
